//--- inc/acq_pkg.sv
// Shared constants for the interferogram acquisition sequencer and its controller.
`default_nettype none
package acq_pkg;
  localparam int SAMPLE_W = 16;
  localparam int LINK_W   = SAMPLE_W + 2;
  localparam int MEM_AW   = 15;
  localparam int FIFO_DEPTH = 8;
  localparam int MMEM_AW  = 15;
  localparam int LW_BIT   = SAMPLE_W + 1;
  localparam int LAST_BIT = SAMPLE_W;
  localparam logic [13:0] POST_COUNT = 14'h2004;
  localparam logic [MEM_AW-1:0] HALF_SPAN  = 15'h2000;
  localparam logic [MEM_AW-1:0] FULL_LAST  = 15'h3fff;
  localparam logic [MEM_AW-1:0] DECIM_LAST = 15'h0fff;
  localparam logic [MEM_AW-1:0] STEP_FULL  = 15'h0001;
  localparam logic [MEM_AW-1:0] STEP_DECIM = 15'h0004;
  localparam int CLK_KHZ        = 40000;
  localparam int CYCLE_LIMIT_MS = 5000;
  localparam int CYCLE_LIMIT_CYC = CYCLE_LIMIT_MS * CLK_KHZ;
endpackage
`default_nettype wire

//--- inc/acq_link_if.sv
// Link between the optical module sequencer and the electronics module controller.
`timescale 1ns/10ps
`default_nettype none
interface acq_link_if;
  logic                           startCmd;
  logic                           decimate;
  logic                           busy;
  logic                           valid;
  logic                           ready;
  logic [acq_pkg::SAMPLE_W-1:0]   data;
  logic                           isLw;
  logic                           last;
  modport optical (input startCmd, input decimate, output busy, output valid, input ready,
                   output data, output isLw, output last);
  modport electronics (output startCmd, output decimate, input busy, input valid,
                       output ready, input data, input isLw, input last);
endinterface
`default_nettype wire

//--- src/optical_end.sv
// Optical module sequencer: pendulum control, sampling, symmetric selection and transfer.
//
// Function
// - Controller issues start for every measurement cycle.
// - Home pendulum before starting the measuring motion.
// - Sample short-wave at each short-wave reference crossing.
// - Sample long-wave at each long-wave reference crossing.
// - Zero path pulse starts the post-pulse counter.
// - Counter at 8196 stops pendulum and sampling.
// - Select 16384 points symmetric about zero path.
// - Start to pendulum stop within five seconds.
// - Transfer all 16384 short-wave samples.
// - Long-wave sent full or decimated to 4096.
// - Controller sends sets to transform processor.
// - Raw mode bypasses transform, writes memory directly.
// - Next start once all data arrived.
// - Execute pending telecommands between cycles.
// - Telemetry served from memory in FIFO order.
`timescale 1ns/10ps
`default_nettype none

module optical_end (
  input  wire logic                         core_clk,
  input  wire logic                         srst,
  acq_link_if.optical                       link,
  output logic                              pendulumHome,
  output logic                              pendulumRun,
  input  wire logic                         atStartPos,
  input  wire logic                         swCross,
  input  wire logic [acq_pkg::SAMPLE_W-1:0] swSample,
  input  wire logic                         lwCross,
  input  wire logic [acq_pkg::SAMPLE_W-1:0] lwSample,
  input  wire logic                         zeroPathPulse
);
  typedef enum logic [2:0] {ST_IDLE, ST_HOME, ST_SAMPLE, ST_SW, ST_LW, ST_FLUSH} seq_state_e;

  logic [acq_pkg::SAMPLE_W-1:0] swMem [2**acq_pkg::MEM_AW];
  logic [acq_pkg::SAMPLE_W-1:0] lwMem [2**acq_pkg::MEM_AW];

  seq_state_e                 state_reg;
  seq_state_e                 state_next;
  logic                       decim_reg;
  logic                       decim_next;
  logic                       busy_reg;
  logic                       busy_next;
  logic                       home_reg;
  logic                       home_next;
  logic                       run_reg;
  logic                       run_next;
  logic                       seenZero_reg;
  logic                       seenZero_next;
  logic [13:0]                postCnt_reg;
  logic [13:0]                postCnt_next;
  logic [acq_pkg::MEM_AW-1:0] wrSw_reg;
  logic [acq_pkg::MEM_AW-1:0] wrSw_next;
  logic [acq_pkg::MEM_AW-1:0] wrLw_reg;
  logic [acq_pkg::MEM_AW-1:0] wrLw_next;
  logic [acq_pkg::MEM_AW-1:0] zeroSw_reg;
  logic [acq_pkg::MEM_AW-1:0] zeroSw_next;
  logic [acq_pkg::MEM_AW-1:0] zeroLw_reg;
  logic [acq_pkg::MEM_AW-1:0] zeroLw_next;
  logic [acq_pkg::MEM_AW-1:0] rdAddr_reg;
  logic [acq_pkg::MEM_AW-1:0] rdAddr_next;
  logic [acq_pkg::MEM_AW-1:0] xferCnt_reg;
  logic [acq_pkg::MEM_AW-1:0] xferCnt_next;

  logic                        fifoInValid;
  logic                        fifoInReady;
  logic [acq_pkg::LINK_W-1:0]  fifoInData;
  logic [acq_pkg::LINK_W-1:0]  fifoOutData;
  logic                        fifoOutValid;
  logic [acq_pkg::MEM_AW-1:0]  lwLastCnt;
  logic [acq_pkg::MEM_AW-1:0]  lwStep;
  logic                        sampling;

  assign sampling    = (state_reg == ST_SAMPLE) && run_reg;
  assign lwLastCnt   = decim_reg ? acq_pkg::DECIM_LAST : acq_pkg::FULL_LAST;
  assign lwStep      = decim_reg ? acq_pkg::STEP_DECIM : acq_pkg::STEP_FULL;
  assign fifoInValid = (state_reg == ST_SW) || (state_reg == ST_LW);
  assign fifoInData  = (state_reg == ST_LW)
                     ? {1'b1, xferCnt_reg == lwLastCnt, lwMem[rdAddr_reg]}
                     : {1'b0, 1'b0, swMem[rdAddr_reg]};

  always_comb begin
    state_next    = state_reg;
    decim_next    = decim_reg;
    busy_next     = busy_reg;
    home_next     = home_reg;
    run_next      = run_reg;
    seenZero_next = seenZero_reg;
    postCnt_next  = postCnt_reg;
    wrSw_next     = (sampling && swCross) ? acq_pkg::MEM_AW'(wrSw_reg + 1'b1) : wrSw_reg;
    wrLw_next     = (sampling && lwCross) ? acq_pkg::MEM_AW'(wrLw_reg + 1'b1) : wrLw_reg;
    zeroSw_next   = zeroSw_reg;
    zeroLw_next   = zeroLw_reg;
    rdAddr_next   = rdAddr_reg;
    xferCnt_next  = xferCnt_reg;
    case (state_reg)
      ST_IDLE: begin
        if (link.startCmd) begin
          decim_next = link.decimate;
          busy_next  = 1'b1;
          home_next  = 1'b1;
          state_next = ST_HOME;
        end
      end
      ST_HOME: begin
        if (atStartPos) begin
          home_next     = 1'b0;
          run_next      = 1'b1;
          seenZero_next = 1'b0;
          postCnt_next  = '0;
          state_next    = ST_SAMPLE;
        end
      end
      ST_SAMPLE: begin
        if (zeroPathPulse && !seenZero_reg) begin
          seenZero_next = 1'b1;
          zeroSw_next   = wrSw_reg;
          zeroLw_next   = wrLw_reg;
        end else if (seenZero_reg && postCnt_reg == acq_pkg::POST_COUNT) begin
          run_next     = 1'b0;
          rdAddr_next  = acq_pkg::MEM_AW'(zeroSw_reg - acq_pkg::HALF_SPAN);
          xferCnt_next = '0;
          state_next   = ST_SW;
        end else if (seenZero_reg && swCross) begin
          postCnt_next = 14'(postCnt_reg + 1'b1);
        end
      end
      ST_SW: begin
        if (fifoInReady) begin
          rdAddr_next  = acq_pkg::MEM_AW'(rdAddr_reg + 1'b1);
          xferCnt_next = acq_pkg::MEM_AW'(xferCnt_reg + 1'b1);
          if (xferCnt_reg == acq_pkg::FULL_LAST) begin
            rdAddr_next  = acq_pkg::MEM_AW'(zeroLw_reg - acq_pkg::HALF_SPAN);
            xferCnt_next = '0;
            state_next   = ST_LW;
          end
        end
      end
      ST_LW: begin
        if (fifoInReady) begin
          rdAddr_next  = acq_pkg::MEM_AW'(rdAddr_reg + lwStep);
          xferCnt_next = acq_pkg::MEM_AW'(xferCnt_reg + 1'b1);
          if (xferCnt_reg == lwLastCnt) begin
            state_next = ST_FLUSH;
          end
        end
      end
      ST_FLUSH: begin
        if (!fifoOutValid) begin
          busy_next  = 1'b0;
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_reg    <= ST_IDLE;
      decim_reg    <= 1'b0;
      busy_reg     <= 1'b0;
      home_reg     <= 1'b0;
      run_reg      <= 1'b0;
      seenZero_reg <= 1'b0;
      postCnt_reg  <= '0;
      wrSw_reg     <= '0;
      wrLw_reg     <= '0;
      zeroSw_reg   <= '0;
      zeroLw_reg   <= '0;
      rdAddr_reg   <= '0;
      xferCnt_reg  <= '0;
    end else begin
      state_reg    <= state_next;
      decim_reg    <= decim_next;
      busy_reg     <= busy_next;
      home_reg     <= home_next;
      run_reg      <= run_next;
      seenZero_reg <= seenZero_next;
      postCnt_reg  <= postCnt_next;
      wrSw_reg     <= wrSw_next;
      wrLw_reg     <= wrLw_next;
      zeroSw_reg   <= zeroSw_next;
      zeroLw_reg   <= zeroLw_next;
      rdAddr_reg   <= rdAddr_next;
      xferCnt_reg  <= xferCnt_next;
    end
  end

  // The sample stores are rings; the motion must give at least half a span before zero path.
  always_ff @(posedge core_clk) begin
    if (sampling && swCross) begin
      swMem[wrSw_reg] <= swSample;
    end
    if (sampling && lwCross) begin
      lwMem[wrLw_reg] <= lwSample;
    end
  end

  sync_fifo #(
    .W     (acq_pkg::LINK_W),
    .DEPTH (acq_pkg::FIFO_DEPTH)
  ) u_fifo (
    .core_clk (core_clk),
    .srst     (srst),
    .inValid  (fifoInValid),
    .inReady  (fifoInReady),
    .inData   (fifoInData),
    .outValid (fifoOutValid),
    .outReady (link.ready),
    .outData  (fifoOutData)
  );

  assign link.busy    = busy_reg;
  assign link.valid   = fifoOutValid;
  assign link.data    = fifoOutData[acq_pkg::SAMPLE_W-1:0];
  assign link.isLw    = fifoOutData[acq_pkg::LW_BIT];
  assign link.last    = fifoOutData[acq_pkg::LAST_BIT];
  assign pendulumHome = home_reg;
  assign pendulumRun  = run_reg;
endmodule
`default_nettype wire

//--- src/electronics_end.sv
// Link FIFO and the electronics module controller: cycle starts, routing, telemetry.
`timescale 1ns/10ps
`default_nettype none

module sync_fifo #(
  parameter int W     = 18,
  parameter int DEPTH = 8
) (
  input  wire logic         core_clk,
  input  wire logic         srst,
  input  wire logic         inValid,
  output logic              inReady,
  input  wire logic [W-1:0] inData,
  output logic              outValid,
  input  wire logic         outReady,
  output logic [W-1:0]      outData
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wrPtr_reg;
  logic [AW-1:0] wrPtr_next;
  logic [AW-1:0] rdPtr_reg;
  logic [AW-1:0] rdPtr_next;
  logic [AW:0]   count_reg;
  logic [AW:0]   count_next;
  logic          push;
  logic          pop;

  assign inReady  = (count_reg != (AW+1)'(DEPTH));
  assign outValid = (count_reg != '0);
  assign outData  = mem[rdPtr_reg];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  always_comb begin
    wrPtr_next = push ? AW'(wrPtr_reg + 1'b1) : wrPtr_reg;
    rdPtr_next = pop ? AW'(rdPtr_reg + 1'b1) : rdPtr_reg;
    count_next = count_reg;
    if (push && !pop) begin
      count_next = (AW+1)'(count_reg + 1'b1);
    end else if (pop && !push) begin
      count_next = (AW+1)'(count_reg - 1'b1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else begin
      wrPtr_reg <= wrPtr_next;
      rdPtr_reg <= rdPtr_next;
      count_reg <= count_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wrPtr_reg] <= inData;
    end
  end
endmodule

module electronics_end #(
  parameter int CYCLE_LIMIT = acq_pkg::CYCLE_LIMIT_CYC
) (
  input  wire logic                         core_clk,
  input  wire logic                         srst,
  acq_link_if.electronics                   link,
  input  wire logic                         runEnable,
  input  wire logic                         rawMode,
  input  wire logic                         decimateMode,
  input  wire logic                         tcPending,
  input  wire logic                         tcDone,
  output logic                              tcExecute,
  output logic                              tpValid,
  output logic [acq_pkg::SAMPLE_W-1:0]      tpData,
  output logic                              tpLw,
  output logic                              tpLast,
  input  wire logic                         tpReady,
  input  wire logic                         tpResValid,
  input  wire logic [acq_pkg::SAMPLE_W-1:0] tpResData,
  input  wire logic                         tmReq,
  output logic                              tmValid,
  output logic [acq_pkg::SAMPLE_W-1:0]      tmData,
  output logic                              tmEmpty,
  output logic                              cycleOverrun
);
  typedef enum logic [2:0] {EC_IDLE, EC_TC, EC_START, EC_WAIT, EC_RECV} ctl_state_e;
  localparam int PW = acq_pkg::MMEM_AW + 1;

  logic [acq_pkg::SAMPLE_W-1:0] massMem [2**acq_pkg::MMEM_AW];

  ctl_state_e              state_reg;
  ctl_state_e              state_next;
  logic                    start_reg;
  logic                    start_next;
  logic                    decim_reg;
  logic                    decim_next;
  logic                    raw_reg;
  logic                    raw_next;
  logic                    tcExec_reg;
  logic                    tcExec_next;
  logic [27:0]             timer_reg;
  logic [27:0]             timer_next;
  logic                    timing_reg;
  logic                    timing_next;
  logic                    overrun_reg;
  logic                    overrun_next;
  logic [PW-1:0]           wrPtr_reg;
  logic [PW-1:0]           wrPtr_next;
  logic [PW-1:0]           rdPtr_reg;
  logic [PW-1:0]           rdPtr_next;
  logic                    tmValid_reg;
  logic                    tmValid_next;
  logic [acq_pkg::SAMPLE_W-1:0] tmData_reg;
  logic [acq_pkg::SAMPLE_W-1:0] tmData_next;

  logic                    memFull;
  logic                    memEmpty;
  logic                    linkTake;
  logic                    memWrite;
  logic [acq_pkg::SAMPLE_W-1:0] memWord;

  assign memFull  = (wrPtr_reg[PW-1] != rdPtr_reg[PW-1]) &&
                    (wrPtr_reg[PW-2:0] == rdPtr_reg[PW-2:0]);
  assign memEmpty = (wrPtr_reg == rdPtr_reg);
  assign link.ready = (state_reg == EC_RECV) && (raw_reg ? !memFull : tpReady);
  assign linkTake   = link.valid && link.ready;
  assign memWrite   = raw_reg ? (linkTake && state_reg == EC_RECV) : (tpResValid && !memFull);
  assign memWord    = raw_reg ? link.data : tpResData;

  always_comb begin
    state_next   = state_reg;
    start_next   = 1'b0;
    decim_next   = decim_reg;
    raw_next     = raw_reg;
    tcExec_next  = 1'b0;
    timer_next   = timer_reg;
    timing_next  = timing_reg;
    overrun_next = overrun_reg;
    wrPtr_next   = memWrite ? PW'(wrPtr_reg + 1'b1) : wrPtr_reg;
    rdPtr_next   = rdPtr_reg;
    tmValid_next = 1'b0;
    tmData_next  = tmData_reg;
    if (tmReq && !memEmpty) begin
      tmValid_next = 1'b1;
      tmData_next  = massMem[rdPtr_reg[PW-2:0]];
      rdPtr_next   = PW'(rdPtr_reg + 1'b1);
    end
    if (timing_reg) begin
      timer_next = 28'(timer_reg + 1'b1);
      if (link.valid) begin
        timing_next = 1'b0;
      end else if (timer_reg == 28'(CYCLE_LIMIT - 1)) begin
        overrun_next = 1'b1;
        timing_next  = 1'b0;
      end
    end
    case (state_reg)
      EC_IDLE: begin
        if (tcPending) begin
          tcExec_next = 1'b1;
          state_next  = EC_TC;
        end else if (runEnable && !link.busy) begin
          start_next   = 1'b1;
          decim_next   = decimateMode;
          raw_next     = rawMode;
          timer_next   = '0;
          timing_next  = 1'b1;
          overrun_next = 1'b0;
          state_next   = EC_START;
        end
      end
      EC_TC: begin
        if (tcDone) begin
          state_next = EC_IDLE;
        end
      end
      EC_START: begin
        state_next = EC_WAIT;
      end
      EC_WAIT: begin
        if (link.busy) begin
          state_next = EC_RECV;
        end
      end
      EC_RECV: begin
        if (linkTake && link.last) begin
          state_next = EC_IDLE;
        end
      end
      default: begin
        state_next = EC_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_reg   <= EC_IDLE;
      start_reg   <= 1'b0;
      decim_reg   <= 1'b0;
      raw_reg     <= 1'b0;
      tcExec_reg  <= 1'b0;
      timer_reg   <= '0;
      timing_reg  <= 1'b0;
      overrun_reg <= 1'b0;
      wrPtr_reg   <= '0;
      rdPtr_reg   <= '0;
      tmValid_reg <= 1'b0;
      tmData_reg  <= '0;
    end else begin
      state_reg   <= state_next;
      start_reg   <= start_next;
      decim_reg   <= decim_next;
      raw_reg     <= raw_next;
      tcExec_reg  <= tcExec_next;
      timer_reg   <= timer_next;
      timing_reg  <= timing_next;
      overrun_reg <= overrun_next;
      wrPtr_reg   <= wrPtr_next;
      rdPtr_reg   <= rdPtr_next;
      tmValid_reg <= tmValid_next;
      tmData_reg  <= tmData_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (memWrite) begin
      massMem[wrPtr_reg[PW-2:0]] <= memWord;
    end
  end

  assign link.startCmd = start_reg;
  assign link.decimate = decim_reg;
  assign tcExecute     = tcExec_reg;
  assign tpValid       = (state_reg == EC_RECV) && !raw_reg && link.valid;
  assign tpData        = link.data;
  assign tpLw          = link.isLw;
  assign tpLast        = link.last;
  assign tmValid       = tmValid_reg;
  assign tmData        = tmData_reg;
  assign tmEmpty       = memEmpty;
  assign cycleOverrun  = overrun_reg;
endmodule
`default_nettype wire

//--- dv/interferogram_acquisition_sequencer_asserts.sv
// Concurrent checks on the link between the optical and electronics ends.
`timescale 1ns/10ps
`default_nettype none
module interferogram_acquisition_sequencer_asserts (
  input wire logic        core_clk,
  input wire logic        srst,
  input wire logic        startCmd,
  input wire logic        decimate,
  input wire logic        busy,
  input wire logic        valid,
  input wire logic        ready,
  input wire logic [15:0] data,
  input wire logic        isLw,
  input wire logic        last
);
  logic [15:0] swCnt_reg, swCnt_next, lwCnt_reg, lwCnt_next;
  logic        take;
  assign take = valid && ready;
  always_comb begin
    swCnt_next = swCnt_reg;
    lwCnt_next = lwCnt_reg;
    if (srst || startCmd) begin
      swCnt_next = 16'h0000;
      lwCnt_next = 16'h0000;
    end else if (take && isLw) begin
      lwCnt_next = lwCnt_reg + 16'h0001;
    end else if (take) begin
      swCnt_next = swCnt_reg + 16'h0001;
    end
  end
  always_ff @(posedge core_clk) begin
    swCnt_reg <= swCnt_next;
    lwCnt_reg <= lwCnt_next;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  start_takes_busy_a: assert property (startCmd && !busy |=> busy && !startCmd)
    else $error("start not followed by busy");
  busy_needs_start_a: assert property ($rose(busy) |-> $past(startCmd))
    else $error("busy rose without a start");
  start_when_idle_a: assert property (startCmd |-> !busy)
    else $error("start issued while busy");
  word_holds_a: assert property (valid && !ready |=> valid && $stable(data) && $stable(last))
    else $error("word changed before it was taken");
  idle_no_data_a: assert property (!busy |-> !valid)
    else $error("word offered while idle");
  mode_held_a: assert property (busy && $past(busy) |-> $stable(decimate))
    else $error("mode changed during cycle");
  sw_first_a: assert property (valid && isLw |-> swCnt_reg == 16'h4000)
    else $error("long-wave word before all short-wave words");
  last_count_a: assert property (take && last |-> isLw && lwCnt_reg == (decimate ? 16'h0fff : 16'h3fff))
    else $error("final word at wrong count");
  lw_no_early_a: assert property (take && isLw && !last |-> lwCnt_reg < (decimate ? 16'h0fff : 16'h3fff))
    else $error("long-wave words beyond count");
  busy_ends_a: assert property (take && last |-> ##[1:4] !busy)
    else $error("busy held after transfer");
  cover property (take && last && decimate);
  cover property (take && last && !decimate);
  cover property (valid && !ready);
endmodule
`default_nettype wire

//--- dv/interferogram_acquisition_sequencer_bench.sv
// Self-checking bench joining the optical and electronics ends of the acquisition link.
`timescale 1ns/10ps
`default_nettype none
module interferogram_acquisition_sequencer_bench;
  logic        core_clk, srst, atStartPos, swCross, lwCross, zeroPathPulse, runEnable, rawMode;
  logic        decimateMode, tcPending, tcDone, tpReady, tpResValid, tmReq, pendulumHome;
  logic        pendulumRun, tcExecute, tpValid, tpLw, tpLast, tmValid, tmEmpty, cycleOverrun;
  logic        curDec, curRaw, linkBusy, expIsLw, expLast;
  logic [15:0] swSample, lwSample, tpResData, tpData, tmData, expWord;
  logic [17:0] expBits;
  logic [15:0] memQ[$];
  int          miscompares = 0, checksDone = 0, seed = 32'hd572, swIdx = 0, lwIdx = 0;
  int          swZero = 0, lwZero = 0, swK = 0, lwK = 0, lastSeen = 0;
  acq_link_if link ();
  assign linkBusy = link.busy;
  optical_end u_optical_end (.core_clk(core_clk), .srst(srst), .link(link.optical),
    .pendulumHome(pendulumHome), .pendulumRun(pendulumRun), .atStartPos(atStartPos),
    .swCross(swCross), .swSample(swSample), .lwCross(lwCross), .lwSample(lwSample),
    .zeroPathPulse(zeroPathPulse));
  electronics_end #(.CYCLE_LIMIT(30000)) u_electronics_end (.core_clk(core_clk), .srst(srst),
    .link(link.electronics), .runEnable(runEnable), .rawMode(rawMode),
    .decimateMode(decimateMode), .tcPending(tcPending), .tcDone(tcDone), .tcExecute(tcExecute),
    .tpValid(tpValid), .tpData(tpData), .tpLw(tpLw), .tpLast(tpLast), .tpReady(tpReady),
    .tpResValid(tpResValid), .tpResData(tpResData), .tmReq(tmReq), .tmValid(tmValid),
    .tmData(tmData), .tmEmpty(tmEmpty), .cycleOverrun(cycleOverrun));
  interferogram_acquisition_sequencer_asserts u_asserts (.core_clk(core_clk), .srst(srst),
    .startCmd(link.startCmd), .decimate(link.decimate), .busy(link.busy), .valid(link.valid),
    .ready(link.ready), .data(link.data), .isLw(link.isLw), .last(link.last));
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checksDone++;
    if (e !== g) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic conclude();
    if (miscompares == 0 && checksDone > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic waitFor(ref logic s, input logic v, input int lim);
    int n;
    n = 0;
    while (s !== v && n < lim) begin
      @(negedge core_clk);
      n++;
    end
    chk("waitFor", 32'(v), 32'(s));
  endtask
  function automatic logic [15:0] expSw(int k);
    return 16'(swZero - 8192 + k);
  endfunction
  function automatic logic [15:0] expLw(int j);
    return 16'(lwZero - 8192 + j * (curDec ? 4 : 1)) ^ 16'h8000;
  endfunction
  // Drives the pendulum phases; crossings before the motion must be ignored.
  task automatic sample(input int pre);
    int   n, s0;
    logic zs;
    n = 0;
    s0 = swIdx;
    zs = 1'b0;
    repeat (3) begin
      @(negedge core_clk);
      {swCross, lwCross, swSample} = {2'b11, 16'hdead};
      chk("homeFirst", 32'h2, 32'({pendulumHome, pendulumRun}));
    end
    atStartPos = 1'b1;
    forever begin
      @(negedge core_clk);
      {swCross, lwCross, zeroPathPulse} = 3'b000;
      n++;
      if (pendulumRun !== 1'b1) begin
        if (zs || n > 60000) break;
        continue;
      end
      atStartPos = 1'b0;
      if (!zs && swIdx - s0 >= pre) begin
        zeroPathPulse = 1'b1;
        swZero = swIdx;
        lwZero = lwIdx;
        zs = 1'b1;
      end else begin
        zeroPathPulse = zs && (swIdx == swZero + 100);
        swCross = ($random(seed) & 7) != 0;
        swSample = 16'(swIdx);
        if (swCross) swIdx++;
        lwCross = 1'b1;
        lwSample = 16'(lwIdx) ^ 16'h8000;
        lwIdx++;
      end
    end
  endtask
  task automatic runCycle(input logic dec, input logic raw, input int cyc);
    {curDec, curRaw, swK, lwK} = {dec, raw, 64'h0};
    {decimateMode, rawMode, runEnable} = {dec, raw, 1'b1};
    waitFor(pendulumHome, 1'b1, 20);
    runEnable = 1'b0;
    chk("busyAtStart", 32'h1, 32'(linkBusy));
    sample(8192 + ($random(seed) & 31));
    waitFor(linkBusy, 1'b0, 60000);
    chk("cyclesDone", 32'(cyc), 32'(lastSeen));
    chk("overrun", 32'h0, 32'(cycleOverrun));
  endtask
  always @(negedge core_clk) tpReady = ($random(seed) & 15) != 0;
  always @(posedge core_clk) begin
    if (!srst && link.valid === 1'b1 && link.ready === 1'b1) begin
      expIsLw = (swK >= 16384);
      expLast = expIsLw && (lwK == (curDec ? 4095 : 16383));
      expWord = expIsLw ? expLw(lwK) : expSw(swK);
      expBits = {expIsLw, expLast, expWord};
      if (!expIsLw) begin
        chk("swWord", 32'(expBits), 32'({link.isLw, link.last, link.data}));
        if (curRaw) memQ.push_back(expWord);
        swK++;
      end else begin
        chk("lwWord", 32'(expBits), 32'({link.isLw, link.last, link.data}));
        lwK++;
      end
      if (curRaw) chk("tpBypass", 32'h0, 32'(tpValid));
      else chk("tpPass", 32'({1'b1, expBits}), 32'({tpValid, tpLw, tpLast, tpData}));
      if (link.last === 1'b1 || expLast) begin
        chk("swCount", 32'h4000, 32'(swK));
        chk("lwCount", curDec ? 32'h1000 : 32'h4000, 32'(lwK));
        lastSeen++;
      end
    end
  end
  initial begin
    {srst, atStartPos, swCross, lwCross, zeroPathPulse, runEnable, rawMode} = 7'h40;
    {decimateMode, tcPending, tcDone, tpResValid, tmReq} = 5'h00;
    {swSample, lwSample, tpResData} = 48'h0;
    repeat (12) @(negedge core_clk);
    srst = 1'b0;
    chk("resetBusy", 32'h0, 32'(linkBusy));
    chk("resetEmpty", 32'h1, 32'(tmEmpty));
    runCycle(1'b0, 1'b0, 1);
    for (int i = 0; i < 3; i++) begin
      @(negedge core_clk);
      tpResValid = 1'b1;
      tpResData = 16'($random(seed));
      memQ.push_back(tpResData);
    end
    @(negedge core_clk);
    tpResValid = 1'b0;
    {tcPending, runEnable} = 2'b11;
    waitFor(tcExecute, 1'b1, 20);
    repeat (5) @(negedge core_clk);
    chk("tcHoldsStart", 32'h0, 32'(linkBusy));
    {tcDone, tcPending} = 2'b10;
    @(negedge core_clk);
    tcDone = 1'b0;
    runCycle(1'b1, 1'b1, 2);
    for (int i = 0; i < 5; i++) begin
      @(negedge core_clk);
      tmReq = 1'b1;
      @(negedge core_clk);
      tmReq = 1'b0;
      waitFor(tmValid, 1'b1, 3);
      chk("tmWord", 32'(memQ[i]), 32'(tmData));
    end
    conclude();
  end
  initial begin
    repeat (99000) @(posedge core_clk);
    miscompares++;
    conclude();
  end
endmodule
`default_nettype wire
